//--- amd_cfg.svh
// constants for the operand addressing decoder
`ifndef AMD_CFG_SVH
`define AMD_CFG_SVH
`define AMD_LEN_INH     3'h1
`define AMD_LEN_IMM     3'h2
`define AMD_LEN_SHORT   3'h2
`define AMD_LEN_LONG    3'h3
`define AMD_MASK_LVL3   2'h3
`define AMD_MASK_LVL0   2'h0
`define AMD_MASK_RESET  2'h3
`endif

//--- amd_pkg.sv
// types for the operand addressing decoder
package amd_pkg;
    // addressing modes presented by the opcode decode
    typedef enum logic [3:0] {
        AMD_INH, AMD_IMM, AMD_DIR_S, AMD_DIR_L, AMD_IDX_0, AMD_IDX_S, AMD_IDX_L,
        AMD_IND_S, AMD_IND_L, AMD_INDX_S, AMD_INDX_L, AMD_REL_D, AMD_REL_I
    } amd_mode_e;
    // inherent operation classes that touch decoder state
    typedef enum logic [1:0] {
        AMD_OP_NONE, AMD_OP_MASK_SET, AMD_OP_MASK_CLEAR
    } amd_inh_e;
    // one decode request from fetch
    typedef struct packed {
        amd_mode_e  mode;
        amd_inh_e   inh;
        logic       use_y;
        logic       short_only;
        logic [7:0] b1;
        logic [7:0] b2;
        logic [15:0] pc;
    } amd_req_s;
    // decode result
    typedef struct packed {
        logic [2:0]  len;
        logic [15:0] ea;
        logic [7:0]  operand;
        logic        is_imm;
        logic        is_rel;
        logic [15:0] pc_target;
        logic        illegal;
    } amd_res_s;
endpackage : amd_pkg

//--- amd_decoder.sv
// operand addressing decoder: length, pointer fetch and effective address
// Function
// [RULE1] inherent op uses opcode byte only, length one
// [RULE2] immediate is two bytes, second byte is the operand
// [RULE3] short direct: one address byte, range 00 to ff
// [RULE4] long direct: two address bytes, full 64k space
// [RULE5] indexed address is unsigned sum of x or y and offset
// [RULE6] indexed no offset: no extra byte, index alone, 00 to ff
// [RULE7] short indexed: one offset byte, sum reaches 00 to 1fe
// [RULE8] long indexed: two offset bytes plus index, full 64k
// [RULE9] indirect: byte after opcode is pointer, read before operand
// [RULE10] short indirect: byte pointer, byte value, 00 to ff
// [RULE11] long indirect: byte pointer locates word, full 64k
// [RULE12] indirect indexed: index plus pointer value from memory
// [RULE13] short indirect indexed: byte pointer plus index, 00 to 1fe
// [RULE14] memory-to-memory and jump ops take short forms only
// [RULE15] relative adds signed 8-bit offset to program counter
// [RULE16] direct relative offset is the byte after opcode
// [RULE17] indirect relative reads offset from address after opcode
// [RULE18] mask set raises level 3, mask clear lowers to level 0
// [RULE19] total instruction length reported to fetch logic
`timescale 1ns/100ps
`default_nettype none
`include "amd_cfg.svh"
module amd_decoder
    import amd_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        sys_rst,
    // request from fetch
    input  wire logic        req_valid,
    output logic             req_ready,
    input  wire amd_req_s    req,
    // index registers
    input  wire logic [7:0]  idx_x,
    input  wire logic [7:0]  idx_y,
    // data memory read port
    output logic             mem_rd,
    output logic [15:0]      mem_addr,
    input  wire logic [7:0]  mem_rdata,
    // result to execute and fetch
    output logic             res_valid,
    output amd_res_s         res,
    output logic [1:0]       irq_mask
);
    typedef enum logic [1:0] {ST_IDLE, ST_PTR_HI, ST_PTR_LO, ST_DONE} amd_state_e;

    amd_state_e  state_q, state_d;
    amd_req_s    cur_q, cur_d;
    logic [15:0] ptr_q, ptr_d;
    amd_res_s    res_q, res_d;
    logic [1:0]  mask_q, mask_d;
    logic [7:0]  idx;
    logic [2:0]  len;
    logic        indirect;
    logic        word_ptr;

    // per-request combinational attributes
    always_comb begin
        idx = req.use_y ? idx_y : idx_x;
        indirect = 1'b0;
        word_ptr = 1'b0;
        case (req.mode)
            AMD_INH:    len = `AMD_LEN_INH;                  // [RULE1]
            AMD_IMM:    len = `AMD_LEN_IMM;                  // [RULE2]
            AMD_DIR_S:  len = `AMD_LEN_SHORT;                // [RULE3]
            AMD_DIR_L:  len = `AMD_LEN_LONG;                 // [RULE4]
            AMD_IDX_0:  len = `AMD_LEN_INH;                  // [RULE6]
            AMD_IDX_S:  len = `AMD_LEN_SHORT;                // [RULE7]
            AMD_IDX_L:  len = `AMD_LEN_LONG;                 // [RULE8]
            AMD_REL_D:  len = `AMD_LEN_SHORT;                // [RULE16]
            AMD_IND_S, AMD_INDX_S, AMD_REL_I: begin
                len = `AMD_LEN_SHORT;                        // [RULE10] [RULE13]
                indirect = 1'b1;                             // [RULE9]
            end
            AMD_IND_L, AMD_INDX_L: begin
                len = `AMD_LEN_SHORT;                        // [RULE11]
                indirect = 1'b1;
                word_ptr = 1'b1;
            end
            default:    len = `AMD_LEN_INH;
        endcase
    end

    // final address and result from a completed pointer or stream
    function automatic amd_res_s finish(amd_req_s r, logic [15:0] p, logic [7:0] ix,
                                        logic [2:0] l);
        amd_res_s o;
        logic [15:0] pc_next;
        o = '0;
        o.len = l;                                           // [RULE19]
        pc_next = r.pc + {13'h0000, l};
        case (r.mode)
            AMD_IMM: begin
                o.is_imm = 1'b1;
                o.operand = r.b1;                            // [RULE2]
            end
            AMD_DIR_S:  o.ea = {8'h00, r.b1};               // [RULE3]
            AMD_DIR_L:  o.ea = {r.b1, r.b2};                // [RULE4]
            AMD_IDX_0:  o.ea = {8'h00, ix};                 // [RULE6]
            AMD_IDX_S:  o.ea = {8'h00, r.b1} + {8'h00, ix}; // [RULE5] [RULE7]
            AMD_IDX_L:  o.ea = {r.b1, r.b2} + {8'h00, ix}; // [RULE8]
            AMD_IND_S:  o.ea = {8'h00, p[7:0]};             // [RULE10]
            AMD_IND_L:  o.ea = p;                            // [RULE11]
            AMD_INDX_S: o.ea = {8'h00, p[7:0]} + {8'h00, ix}; // [RULE13]
            AMD_INDX_L: o.ea = p + {8'h00, ix};             // [RULE12]
            AMD_REL_D: begin
                o.is_rel = 1'b1;                             // [RULE16]
                o.pc_target = pc_next + {{8{r.b1[7]}}, r.b1}; // [RULE15]
            end
            AMD_REL_I: begin
                o.is_rel = 1'b1;                             // [RULE17]
                o.pc_target = pc_next + {{8{p[7]}}, p[7:0]};
            end
            default:    o.ea = 16'h0000;
        endcase
        // long forms refused for short-only operations
        o.illegal = r.short_only && (r.mode == AMD_DIR_L || r.mode == AMD_IDX_L
                    || r.mode == AMD_IND_L || r.mode == AMD_INDX_L); // [RULE14]
        return o;
    endfunction : finish

    // sequencer next state
    always_comb begin
        state_d = state_q;
        cur_d = cur_q;
        ptr_d = ptr_q;
        res_d = res_q;
        mask_d = mask_q;
        case (state_q)
            ST_IDLE: begin
                if (req_valid) begin
                    cur_d = req;
                    if (req.mode == AMD_INH) begin
                        if (req.inh == AMD_OP_MASK_SET) mask_d = `AMD_MASK_LVL3;   // [RULE18]
                        if (req.inh == AMD_OP_MASK_CLEAR) mask_d = `AMD_MASK_LVL0; // [RULE18]
                    end
                    if (indirect) begin
                        state_d = word_ptr ? ST_PTR_HI : ST_PTR_LO; // [RULE9]
                    end else begin
                        res_d = finish(req, 16'h0000, idx, len);
                        state_d = ST_DONE;
                    end
                end
            end
            ST_PTR_HI: begin
                ptr_d[15:8] = mem_rdata;                     // [RULE11]
                state_d = ST_PTR_LO;
            end
            ST_PTR_LO: begin
                ptr_d[7:0] = mem_rdata;
                if (cur_q.mode != AMD_IND_L && cur_q.mode != AMD_INDX_L) begin
                    ptr_d[15:8] = 8'h00;
                end
                res_d = finish(cur_q, {ptr_d[15:8], mem_rdata},
                               cur_q.use_y ? idx_y : idx_x, `AMD_LEN_SHORT); // [RULE12]
                state_d = ST_DONE;
            end
            ST_DONE:  state_d = ST_IDLE;
            default:  state_d = ST_IDLE;
        endcase
    end

    // registers
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
            cur_q <= '0;
            ptr_q <= 16'h0000;
            res_q <= '0;
            mask_q <= `AMD_MASK_RESET;
        end else begin
            state_q <= state_d;
            cur_q <= cur_d;
            ptr_q <= ptr_d;
            res_q <= res_d;
            mask_q <= mask_d;
        end
    end

    // memory read: pointer word high byte first, then low byte
    always_comb begin
        mem_rd = (state_q == ST_PTR_HI) || (state_q == ST_PTR_LO);
        case (state_q)
            ST_PTR_HI: mem_addr = {8'h00, cur_q.b1};         // [RULE9]
            ST_PTR_LO: mem_addr = (cur_q.mode == AMD_IND_L || cur_q.mode == AMD_INDX_L)
                                  ? {8'h00, cur_q.b1 + 8'h01} : {8'h00, cur_q.b1};
            default:   mem_addr = 16'h0000;
        endcase
    end

    assign req_ready = (state_q == ST_IDLE);
    assign res_valid = (state_q == ST_DONE);
    assign res = res_q;
    assign irq_mask = mask_q;

    // checks: inherent, immediate and direct forms answer one cycle after the take
    a_len_inherent: assert property (@(posedge clock) disable iff (sys_rst) // [RULE1]
        req_valid && req_ready && req.mode == AMD_INH
        |=> res_valid && !mem_rd && res.len == 3'h1)
        else $error("inherent length wrong");
    a_imm_operand: assert property (@(posedge clock) disable iff (sys_rst) // [RULE2]
        req_valid && req_ready && req.mode == AMD_IMM
        |=> res.is_imm && res.len == 3'h2 && res.operand == $past(req.b1))
        else $error("immediate operand wrong");
    a_len_direct_short: assert property (@(posedge clock) disable iff (sys_rst) // [RULE3]
        req_valid && req_ready && req.mode == AMD_DIR_S
        |=> res_valid && res.len == 3'h2 && res.ea == {8'h00, $past(req.b1)})
        else $error("short direct result wrong");
    a_long_direct: assert property (@(posedge clock) disable iff (sys_rst) // [RULE4]
        req_valid && req_ready && req.mode == AMD_DIR_L
        |=> res.len == 3'h3 && res.ea == {$past(req.b1), $past(req.b2)})
        else $error("long direct address wrong");

    // indexed forms: unsigned sum of the index and the offset
    a_idx_none: assert property (@(posedge clock) disable iff (sys_rst) // [RULE6]
        req_valid && req_ready && req.mode == AMD_IDX_0 && !req.use_y
        |=> res.len == 3'h1 && !mem_rd && res.ea == {8'h00, $past(idx_x)})
        else $error("indexed no offset wrong");
    a_idx_short_sum: assert property (@(posedge clock) disable iff (sys_rst) // [RULE7]
        req_valid && req_ready && req.mode == AMD_IDX_S && !req.use_y
        |=> res.ea == {8'h00, $past(req.b1)} + {8'h00, $past(idx_x)})
        else $error("short indexed sum wrong");
    a_idx_long_sum: assert property (@(posedge clock) disable iff (sys_rst) // [RULE8]
        req_valid && req_ready && req.mode == AMD_IDX_L && req.use_y
        |=> res.len == 3'h3 && res.ea == {$past(req.b1), $past(req.b2)} + {8'h00, $past(idx_y)})
        else $error("long indexed sum wrong");

    // word pointer: high byte read, low byte read, then the result
    sequence s_ptr_word;
        mem_rd && state_q == ST_PTR_HI ##1 mem_rd && state_q == ST_PTR_LO ##1 res_valid;
    endsequence
    // byte pointer or offset: one read, then a two-byte result
    sequence s_ptr_byte;
        mem_rd && state_q == ST_PTR_LO ##1 res_valid && res.len == 3'h2;
    endsequence
    // every pointer walk starts at the byte after the opcode
    a_ptr_addr: assert property (@(posedge clock) disable iff (sys_rst) // [RULE9]
        req_valid && req_ready && indirect
        |=> mem_rd && mem_addr == {8'h00, $past(req.b1)})
        else $error("pointer address wrong");
    a_ptr_lo_addr: assert property (@(posedge clock) disable iff (sys_rst) // [RULE11]
        req_valid && req_ready && word_ptr
        |=> ##1 mem_rd && mem_addr == {8'h00, $past(req.b1, 2) + 8'h01})
        else $error("pointer low byte address wrong");
    a_ind_long_walk: assert property (@(posedge clock) disable iff (sys_rst) // [RULE11]
        req_valid && req_ready && req.mode == AMD_IND_L |=> s_ptr_word)
        else $error("long indirect pointer walk wrong");
    a_indx_long_walk: assert property (@(posedge clock) disable iff (sys_rst) // [RULE12]
        req_valid && req_ready && req.mode == AMD_INDX_L |=> s_ptr_word)
        else $error("long indirect indexed walk wrong");
    a_ind_short_walk: assert property (@(posedge clock) disable iff (sys_rst) // [RULE10]
        req_valid && req_ready && req.mode == AMD_IND_S |=> s_ptr_byte)
        else $error("short indirect sequence wrong");
    a_indx_short_walk: assert property (@(posedge clock) disable iff (sys_rst) // [RULE13]
        req_valid && req_ready && req.mode == AMD_INDX_S |=> s_ptr_byte)
        else $error("short indirect indexed walk wrong");

    // relative forms: signed offset added to the next instruction address
    a_rel_d_len: assert property (@(posedge clock) disable iff (sys_rst) // [RULE16]
        req_valid && req_ready && req.mode == AMD_REL_D
        |=> res_valid && !mem_rd && res.len == 3'h2)
        else $error("direct relative length wrong");
    a_rel_direct: assert property (@(posedge clock) disable iff (sys_rst) // [RULE15]
        req_valid && req_ready && req.mode == AMD_REL_D
        |=> res.is_rel && res.pc_target == $past(req.pc) + 16'h0002
            + {{8{$past(req.b1[7])}}, $past(req.b1)})
        else $error("relative target wrong");
    a_rel_ind_walk: assert property (@(posedge clock) disable iff (sys_rst) // [RULE17]
        req_valid && req_ready && req.mode == AMD_REL_I |=> s_ptr_byte ##0 res.is_rel)
        else $error("indirect relative walk wrong");

    // interrupt mask level: moved only by the two mask ops
    a_mask_set: assert property (@(posedge clock) disable iff (sys_rst) // [RULE18]
        req_valid && req_ready && req.mode == AMD_INH && req.inh == AMD_OP_MASK_SET
        |=> irq_mask == 2'h3)
        else $error("mask set level wrong");
    a_mask_clear: assert property (@(posedge clock) disable iff (sys_rst) // [RULE18]
        req_valid && req_ready && req.mode == AMD_INH && req.inh == AMD_OP_MASK_CLEAR
        |=> irq_mask == 2'h0)
        else $error("mask clear level wrong");
    a_mask_hold: assert property (@(posedge clock) disable iff (sys_rst) // [RULE18]
        !(req_valid && req_ready && req.mode == AMD_INH && req.inh != AMD_OP_NONE)
        |=> $stable(irq_mask))
        else $error("mask moved without a mask op");

    // long forms refused for short-only ops
    a_short_only: assert property (@(posedge clock) disable iff (sys_rst) // [RULE14]
        req_valid && req_ready && req.short_only && req.mode == AMD_DIR_L
        |=> res.illegal)
        else $error("long form not refused");
    a_short_ok: assert property (@(posedge clock) disable iff (sys_rst) // [RULE14]
        req_valid && req_ready && req.short_only && req.mode == AMD_DIR_S
        |=> !res.illegal)
        else $error("short form refused");

    // one result pulse, then ready again; idle values under reset
    a_result_pulse: assert property (@(posedge clock) disable iff (sys_rst) // [RULE19]
        res_valid |=> !res_valid && req_ready)
        else $error("result pulse too long");
    a_reset_state: assert property (@(posedge clock) // [RULE18]
        sys_rst |=> irq_mask == 2'h3 && req_ready && !res_valid && !mem_rd)
        else $error("reset state wrong");
endmodule : amd_decoder
`default_nettype wire

//--- cpu_addressing_mode_decoder_test.sv
// self-checking testbench for the operand addressing decoder
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, a) begin cmp_count++; if ((a) !== (e)) begin miscompares++; \
    $display("mismatch %s exp %h got %h", nm, e, a); end end
module cpu_addressing_mode_decoder_test
    import amd_pkg::*;
;
    logic        clock, sys_rst, req_valid, req_ready, mem_rd, res_valid;
    amd_req_s    req;
    logic [7:0]  idx_x, idx_y, mem_rdata;
    logic [15:0] mem_addr, rd_first;
    amd_res_s    res, r;
    logic [1:0]  irq_mask;
    int          miscompares = 0;
    int          cmp_count = 0;
    // data pattern held at each memory address
    function automatic logic [7:0] mdat(input logic [15:0] a);
        return a[7:0] ^ 8'ha5;
    endfunction : mdat
    // combinational memory; an idle bus shows the inverted address
    assign mem_rdata = mem_rd ? mdat(mem_addr) : ~mem_addr[7:0];
    amd_decoder amd_decoder_inst (.clock(clock), .sys_rst(sys_rst), .req_valid(req_valid),
        .req_ready(req_ready), .req(req), .idx_x(idx_x), .idx_y(idx_y), .mem_rd(mem_rd),
        .mem_addr(mem_addr), .mem_rdata(mem_rdata), .res_valid(res_valid), .res(res),
        .irq_mask(irq_mask));
    // 25 MHz clock
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    // counts and verdict
    task results;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : results
    // one decode: take, wait for result, check latency and length
    task automatic issue(input amd_mode_e m, input amd_inh_e op, input logic y, so,
        input logic [7:0] a, b, input logic [15:0] p, input int lat, input logic [2:0] len);
        int n;
        req = '{mode: m, inh: op, use_y: y, short_only: so, b1: a, b2: b, pc: p};
        req_valid = 1'b1;
        @(posedge clock);
        #1;
        req_valid = 1'b0;
        rd_first = mem_addr;
        n = 1;
        while (res_valid !== 1'b1 && n < 8) begin
            @(posedge clock);
            #1;
            n++;
        end
        r = res;
        if (lat > 0) begin
            `CHK("latency", lat, n)
            `CHK("len", len, r.len)
        end
        @(posedge clock);
        #1;
    endtask : issue
    task t_reset;
        `CHK("mask", 2'h3, irq_mask)
        `CHK("ready", 1'b1, req_ready)
        $display("test reset done");
    endtask : t_reset
    task t_inherent;
        issue(AMD_INH, AMD_OP_MASK_CLEAR, 0, 0, 8'h00, 8'h00, 16'h0, 1, 3'h1);
        `CHK("mask", 2'h0, irq_mask)
        issue(AMD_INH, AMD_OP_NONE, 0, 0, 8'h00, 8'h00, 16'h0, 1, 3'h1);
        `CHK("mask", 2'h0, irq_mask)
        issue(AMD_INH, AMD_OP_MASK_SET, 0, 0, 8'h00, 8'h00, 16'h0, 1, 3'h1);
        `CHK("mask", 2'h3, irq_mask)
        $display("test inherent done");
    endtask : t_inherent
    task t_immediate;
        issue(AMD_IMM, AMD_OP_NONE, 0, 0, 8'h55, 8'h00, 16'h0, 1, 3'h2);
        `CHK("operand", 8'h55, r.operand)
        `CHK("is_imm", 1'b1, r.is_imm)
        $display("test immediate done");
    endtask : t_immediate
    task t_direct;
        issue(AMD_DIR_S, AMD_OP_NONE, 0, 0, 8'hff, 8'h00, 16'h0, 1, 3'h2);
        `CHK("ea", 16'h00ff, r.ea)
        issue(AMD_DIR_L, AMD_OP_NONE, 0, 0, 8'h12, 8'h34, 16'h0, 1, 3'h3);
        `CHK("ea", 16'h1234, r.ea)
        $display("test direct done");
    endtask : t_direct
    task t_indexed;
        issue(AMD_IDX_0, AMD_OP_NONE, 0, 0, 8'h77, 8'h00, 16'h0, 1, 3'h1);
        `CHK("ea", 16'h00ff, r.ea)
        issue(AMD_IDX_S, AMD_OP_NONE, 0, 0, 8'hff, 8'h00, 16'h0, 1, 3'h2);
        `CHK("ea", 16'h01fe, r.ea)
        issue(AMD_IDX_L, AMD_OP_NONE, 1, 0, 8'h12, 8'hf0, 16'h0, 1, 3'h3);
        `CHK("ea", 16'h1311, r.ea)
        $display("test indexed done");
    endtask : t_indexed
    task t_indirect;
        issue(AMD_IND_S, AMD_OP_NONE, 0, 0, 8'h40, 8'h00, 16'h0, 2, 3'h2);
        `CHK("ptr", 16'h0040, rd_first)
        `CHK("ea", {8'h00, mdat(16'h0040)}, r.ea)
        issue(AMD_IND_L, AMD_OP_NONE, 0, 0, 8'h40, 8'h00, 16'h0, 3, 3'h2);
        `CHK("ea", {mdat(16'h0040), mdat(16'h0041)}, r.ea)
        $display("test indirect done");
    endtask : t_indirect
    task t_ind_indexed;
        issue(AMD_INDX_S, AMD_OP_NONE, 0, 0, 8'h40, 8'h00, 16'h0, 2, 3'h2);
        `CHK("ea", {8'h00, mdat(16'h0040)} + {8'h00, idx_x}, r.ea)
        issue(AMD_INDX_L, AMD_OP_NONE, 1, 0, 8'h40, 8'h00, 16'h0, 3, 3'h2);
        `CHK("ea", {mdat(16'h0040), mdat(16'h0041)} + {8'h00, idx_y}, r.ea)
        $display("test indirect indexed done");
    endtask : t_ind_indexed
    task t_relative;
        logic [7:0] d;
        d = mdat(16'h0030);
        issue(AMD_REL_D, AMD_OP_NONE, 0, 0, 8'hfe, 8'h00, 16'h1000, 1, 3'h2);
        `CHK("target", 16'h1000, r.pc_target)
        `CHK("is_rel", 1'b1, r.is_rel)
        issue(AMD_REL_I, AMD_OP_NONE, 0, 0, 8'h30, 8'h00, 16'h1000, 2, 3'h2);
        `CHK("target", 16'h1002 + {{8{d[7]}}, d}, r.pc_target)
        $display("test relative done");
    endtask : t_relative
    task t_short_only;
        issue(AMD_DIR_L, AMD_OP_NONE, 0, 1, 8'h12, 8'h34, 16'h0, 1, 3'h3);
        `CHK("illegal", 1'b1, r.illegal)
        issue(AMD_IDX_L, AMD_OP_NONE, 0, 1, 8'h12, 8'h34, 16'h0, 1, 3'h3);
        `CHK("illegal", 1'b1, r.illegal)
        issue(AMD_DIR_S, AMD_OP_NONE, 0, 1, 8'h12, 8'h00, 16'h0, 1, 3'h2);
        `CHK("illegal", 1'b0, r.illegal)
        $display("test short only done");
    endtask : t_short_only
    // second request offered while the first is still walking its pointer
    task t_busy;
        int k;
        req = '{mode: AMD_IND_L, inh: AMD_OP_NONE, use_y: 1'b0, short_only: 1'b0,
                b1: 8'h40, b2: 8'h00, pc: 16'h0000};
        req_valid = 1'b1;
        @(posedge clock);
        #1;
        req = '{mode: AMD_IND_S, inh: AMD_OP_NONE, use_y: 1'b0, short_only: 1'b0,
                b1: 8'h50, b2: 8'h00, pc: 16'h0000};
        `CHK("ready", 1'b0, req_ready)
        k = 0;
        while (res_valid !== 1'b1 && k < 8) begin
            @(posedge clock);
            #1;
            k++;
        end
        `CHK("latency", 2, k)
        `CHK("ea", {mdat(16'h0040), mdat(16'h0041)}, res.ea)
        @(posedge clock);
        #1;
        issue(AMD_IND_S, AMD_OP_NONE, 0, 0, 8'h50, 8'h00, 16'h0, 2, 3'h2);
        `CHK("ea", {8'h00, mdat(16'h0050)}, r.ea)
        $display("test busy hold done");
    endtask : t_busy
    // reset in mid-run returns the mask and the handshake to idle values
    task t_mid_reset;
        issue(AMD_INH, AMD_OP_MASK_CLEAR, 0, 0, 8'h00, 8'h00, 16'h0, 1, 3'h1);
        `CHK("mask", 2'h0, irq_mask)
        sys_rst = 1'b1;
        repeat (2) @(posedge clock);
        #1;
        sys_rst = 1'b0;
        `CHK("mask", 2'h3, irq_mask)
        `CHK("ready", 1'b1, req_ready)
        `CHK("res_valid", 1'b0, res_valid)
        `CHK("len", 3'h0, res.len)
        $display("test mid reset done");
    endtask : t_mid_reset
    // watchdog: tests need well under 200 cycles
    initial begin
        #(40 * 3000);
        miscompares++;
        results();
    end
    // main sequence
    initial begin
        sys_rst = 1'b1;
        req_valid = 1'b0;
        req = '0;
        idx_x = 8'hff;
        idx_y = 8'h21;
        repeat (10) @(posedge clock);
        #1;
        sys_rst = 1'b0;
        t_reset();
        t_inherent();
        t_immediate();
        t_direct();
        t_indexed();
        t_indirect();
        t_ind_indexed();
        t_relative();
        t_busy();
        t_mid_reset();
        t_short_only();
        results();
    end
endmodule : cpu_addressing_mode_decoder_test
`default_nettype wire
